/* e1_framer_model.sv */
// Framer model: transmit clock and data source, recovered clock edge counter
`timescale 1ns/100ps
`default_nettype none
module e1_framer_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Recovered clock from the interface
  input wire logic rx_clk,
  // Transmit side toward the interface, and the recovered clock rise count
  output logic tx_clk,
  output logic tx_data,
  output logic [15:0] rx_rises
);
  logic [2:0] div_reg;
  logic rx_clk_d_reg;
  // Transmit clock at an eighth of the master clock, slow enough for the pin sampler
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end
  assign tx_clk = div_reg[2];
  // Steady marks, so inserted zeros stand out from normal data
  assign tx_data = 1'b1;
  // Count recovered clock rises; the clock is a register output, so sampling is safe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_clk_d_reg <= 1'b0;
      rx_rises <= 16'h0;
    end else begin
      rx_clk_d_reg <= rx_clk;
      if (rx_clk && !rx_clk_d_reg) rx_rises <= rx_rises + 16'h1;
    end
  end
endmodule
`default_nettype wire

/* e1_rx_config_diag_regs.sv */
// E1 receive configuration and diagnostic pattern register bank with its datapath
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "e1_rx_defines.svh"
module e1_rx_config_diag_regs import e1_rx_pkg::*; (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // AXI4-Lite write channels
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read channels
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Receive line side, asynchronous
  input wire logic RX_POS_IN,
  input wire logic RX_NEG_IN,
  input wire logic RX_SLICE_POS_IN,
  input wire logic RX_SLICE_NEG_IN,
  input wire logic RX_CLK_IN,
  input wire logic LOS_IN,
  // Transmit side
  input wire logic TX_CLOCK_IN,
  input wire logic TX_DATA_IN,
  output logic TX_DATA_OUT,
  // Receive system side
  output logic RX_DATA_OUT,
  output logic RX_PLUS_RAIL_OUT,
  output logic RX_MINUS_RAIL_OUT,
  output logic RX_CLK_OUT,
  output logic PRBS_ERR_OUT,
  // Analog front end settings
  output analog_ctrl_t ANALOG_CTRL
);

  // Address decode shared by read and write paths
  function automatic reg_sel_t reg_hit(input logic [7:0] a);
    reg_sel_t r;
    r = REG_NONE;
    if (a[1:0] == 2'h0) begin
      unique case (a[7:2])
        `IDX_RX_FMT: r = REG_FMT;
        `IDX_RX_EQ: r = REG_EQ;
        `IDX_RX_SLG: r = REG_SLG;
        `IDX_DIAG: r = REG_DIAG;
        `IDX_STATUS: r = REG_STAT;
        default: r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  logic [7:0] fmt_reg, eq_reg, slg_reg, diag_reg, status;
  logic aw_full_reg, w_full_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  wr_state_t wr_state_reg;
  logic do_write;
  reg_sel_t wr_hit;

  // Handshakes; one write and one read outstanding at most
  assign AWREADY = !aw_full_reg && (wr_state_reg == WR_IDLE);
  assign WREADY = !w_full_reg && (wr_state_reg == WR_IDLE);
  assign BVALID = (wr_state_reg == WR_RESP);
  assign BRESP = bresp_reg;
  assign ARREADY = !rvalid_reg;
  assign RVALID = rvalid_reg;
  assign RDATA = rdata_reg;
  assign RRESP = rresp_reg;
  assign do_write = aw_full_reg && w_full_reg && (wr_state_reg == WR_IDLE);
  assign wr_hit = reg_hit(awaddr_reg);

  // Write address capture, independent of write data order
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (AWVALID && AWREADY) begin
      aw_full_reg <= 1'b1;
      awaddr_reg <= AWADDR;
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_full_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (WVALID && WREADY) begin
      w_full_reg <= 1'b1;
      wdata_reg <= WDATA;
      wstrb_reg <= WSTRB;
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end
  end

  // Write response state
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_state_reg <= WR_IDLE;
      bresp_reg <= `RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        WR_IDLE: begin
          if (do_write) begin
            wr_state_reg <= WR_RESP;
            bresp_reg <= (wr_hit == REG_NONE) ? `RESP_DECERR : `RESP_OKAY;
          end
        end
        WR_RESP: begin
          if (BREADY) begin
            wr_state_reg <= WR_IDLE;
          end
        end
        default: wr_state_reg <= WR_IDLE;
      endcase
    end
  end

  // reserved bits kept
  // Only writable bits change, so reserved bits always hold their defaults
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fmt_reg <= `RST_RX_FMT;
      eq_reg <= `RST_RX_EQ;
      slg_reg <= `RST_RX_SLG;
      diag_reg <= `RST_DIAG;
    end else if (do_write && wstrb_reg[0]) begin
      if (wr_hit == REG_FMT)
        fmt_reg <= (wdata_reg[7:0] & `WM_RX_FMT) | (`RST_RX_FMT & ~`WM_RX_FMT);
      if (wr_hit == REG_EQ)
        eq_reg <= (wdata_reg[7:0] & `WM_RX_EQ) | (`RST_RX_EQ & ~`WM_RX_EQ);
      if (wr_hit == REG_SLG)
        slg_reg <= (wdata_reg[7:0] & `WM_RX_SLG) | (`RST_RX_SLG & ~`WM_RX_SLG);
      if (wr_hit == REG_DIAG)
        diag_reg <= (wdata_reg[7:0] & `WM_DIAG) | (`RST_DIAG & ~`WM_DIAG);
    end
  end

  // Read channel; unmapped addresses answer DECERR with zero data
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= `RESP_OKAY;
      unique case (reg_hit(ARADDR))
        REG_FMT: rdata_reg <= {24'h000000, fmt_reg};
        REG_EQ: rdata_reg <= {24'h000000, eq_reg};
        REG_SLG: rdata_reg <= {24'h000000, slg_reg};
        REG_DIAG: rdata_reg <= {24'h000000, diag_reg};
        REG_STAT: rdata_reg <= {24'h000000, status};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `RESP_DECERR;
        end
      endcase
    end else if (rvalid_reg && RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Field views of the control registers
  decode_mode_t mode;
  pattern_t patt;
  logic pd, inv, edge_sel, pclk_src, pinv, ais_fill, ones_fill;
  assign mode = decode_mode_t'(fmt_reg[1:0]);
  assign pd = fmt_reg[`RX_OFF_BIT];
  assign inv = fmt_reg[`RX_POL_BIT];
  assign edge_sel = fmt_reg[`RX_EDGE_BIT];
  assign patt = pattern_t'(diag_reg[`TSEQ_LSB +: 2]);
  assign pclk_src = diag_reg[`PCLK_BIT];
  assign pinv = diag_reg[`PINV_BIT];
  assign ais_fill = diag_reg[`AIS_FILL_BIT];
  assign ones_fill = diag_reg[`ONES_FILL_BIT];

  // reserved codes clamped
  // Analog settings registered; reserved threshold codes clamp to the highest level
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ANALOG_CTRL <= '0;
    end else begin
      ANALOG_CTRL.rx_power_down <= pd;
      ANALOG_CTRL.equalizer_switch <= eq_reg[`EQ_SWITCH_BIT];
      if (!eq_reg[`EQ_SWITCH_BIT])
        ANALOG_CTRL.signal_absent_threshold <= `RST_LOS;
      else if (eq_reg[`LOS_LSB +: 5] > `LOS_MAX)
        ANALOG_CTRL.signal_absent_threshold <= `LOS_MAX;
      else
        ANALOG_CTRL.signal_absent_threshold <= eq_reg[`LOS_LSB +: 5];
      ANALOG_CTRL.detector_threshold_sel <= slg_reg[`SLICE_LSB +: 2];
      ANALOG_CTRL.monitor_boost <= slg_reg[`GAIN_LSB +: 2];
      ANALOG_CTRL.alarm_criterion_sel <= diag_reg[`CRIT_BIT];
    end
  end

  // Two-stage synchronisers for all eight line and transmit input pins; first stage read only by the second
  logic [7:0] sync1_reg, sync2_reg;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= {TX_DATA_IN, TX_CLOCK_IN, LOS_IN, RX_CLK_IN,
                    RX_SLICE_NEG_IN, RX_SLICE_POS_IN, RX_NEG_IN, RX_POS_IN};
      sync2_reg <= sync1_reg;
    end
  end
  logic pos_s, neg_s, spos_s, sneg_s, rclk_s, los_s, txclk_s, tdat_s;
  assign {tdat_s, txclk_s, los_s, rclk_s, sneg_s, spos_s, neg_s, pos_s} = sync2_reg;

  // Edge detection on the recovered and transmit clocks
  logic rclk_prev_reg, txclk_prev_reg;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rclk_prev_reg <= 1'b0;
      txclk_prev_reg <= 1'b0;
    end else begin
      rclk_prev_reg <= rclk_s;
      txclk_prev_reg <= txclk_s;
    end
  end
  logic bit_tick, txclk_rise, pat_tick, ais_active;
  assign bit_tick = edge_sel ? (!rclk_s && rclk_prev_reg) : (rclk_s && !rclk_prev_reg);
  assign txclk_rise = txclk_s && !txclk_prev_reg;
  assign pat_tick = pclk_src ? 1'b1 : txclk_rise;
  assign ais_active = ais_fill && los_s;

  // HDB3/AMI decoder; a violation erases itself and the three bits before it
  logic [3:0] hist_reg;
  logic last_pol_reg, mark, viol;
  assign mark = pos_s || neg_s;
  assign viol = mark && (pos_s == last_pol_reg);
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hist_reg <= 4'h0;
      last_pol_reg <= 1'b0;
    end else if (bit_tick) begin
      if (mark)
        last_pol_reg <= pos_s;
      if (viol && mode == DEC_HDB3)
        hist_reg <= 4'h0;
      else
        hist_reg <= {hist_reg[2:0], mark};
    end
  end

  // AIS fill: divided master clock and alternating marks
  logic ais_div_reg, ais_ph_reg;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ais_div_reg <= 1'b0;
      ais_ph_reg <= 1'b0;
    end else begin
      ais_div_reg <= !ais_div_reg;
      if (ais_div_reg)
        ais_ph_reg <= !ais_ph_reg;
    end
  end

  // Receive output stage; powered down receiver drives everything low
  logic rd_reg, rp_reg, rn_reg, rclk_out_reg;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_reg <= 1'b0;
      rp_reg <= 1'b0;
      rn_reg <= 1'b0;
      rclk_out_reg <= 1'b0;
    end else if (pd) begin
      rd_reg <= 1'b0;
      rp_reg <= 1'b0;
      rn_reg <= 1'b0;
      rclk_out_reg <= 1'b0;
    end else if (ais_active) begin
      rd_reg <= !inv;
      rp_reg <= ais_ph_reg ^ inv;
      rn_reg <= !ais_ph_reg ^ inv;
      rclk_out_reg <= ais_div_reg;
    end else begin
      rclk_out_reg <= rclk_s;
      unique case (mode)
        DEC_HDB3, DEC_AMI: begin
          rp_reg <= 1'b0;
          rn_reg <= 1'b0;
          if (bit_tick)
            rd_reg <= hist_reg[3] ^ inv;
        end
        DEC_DUAL: begin
          rd_reg <= 1'b0;
          if (bit_tick) begin
            rp_reg <= pos_s ^ inv;
            rn_reg <= neg_s ^ inv;
          end
        end
        DEC_SLICER: begin
          rd_reg <= 1'b0;
          rp_reg <= spos_s ^ inv;
          rn_reg <= sneg_s ^ inv;
        end
      endcase
    end
  end
  assign RX_DATA_OUT = rd_reg;
  assign RX_PLUS_RAIL_OUT = rp_reg;
  assign RX_MINUS_RAIL_OUT = rn_reg;
  assign RX_CLK_OUT = rclk_out_reg;

  // Transmit PRBS generator, x^15 + x^14 + 1
  logic [14:0] prbs_reg;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      prbs_reg <= `PRBS_SEED;
    else if (pat_tick)
      prbs_reg <= {prbs_reg[13:0], prbs_reg[14] ^ prbs_reg[13]};
  end

  // Transmit stream selection; reserved pattern code passes data through
  logic tx_reg, tx_override;
  assign tx_override = (patt == PAT_ONES) || (patt == PAT_PRBS) || pclk_src ||
                       (ones_fill && los_s && patt == PAT_NORMAL);
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_reg <= 1'b0;
    end else if (patt == PAT_NORMAL && ones_fill && los_s) begin
      if (pat_tick)
        tx_reg <= 1'b1;
    end else begin
      unique case (patt)
        PAT_NORMAL: begin
          if (pclk_src)
            tx_reg <= 1'b0;
          else if (txclk_rise)
            tx_reg <= tdat_s;
        end
        PAT_ONES: if (pat_tick) tx_reg <= 1'b1;
        PAT_PRBS: if (pat_tick) tx_reg <= prbs_reg[14] ^ pinv;
        PAT_RSVD: if (txclk_rise) tx_reg <= tdat_s;
      endcase
    end
  end
  assign TX_DATA_OUT = tx_reg;

  // Receive PRBS checker, self-synchronising on the decoded stream
  logic [14:0] chk_reg;
  logic err_reg, chk_bit;
  assign chk_bit = hist_reg[3] ^ pinv;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      chk_reg <= 15'h0000;
      err_reg <= 1'b0;
    end else begin
      err_reg <= 1'b0;
      if (bit_tick && patt == PAT_PRBS) begin
        chk_reg <= {chk_reg[13:0], chk_bit};
        err_reg <= (chk_reg[14] ^ chk_reg[13]) != chk_bit;
      end
    end
  end
  assign PRBS_ERR_OUT = err_reg;

  // Status view of live block state
  assign status = {5'h00, ais_active, tx_override, los_s};

  // Checks on the logic above
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  sequence s_write_taken;
    do_write ##1 BVALID;
  endsequence
  a_write_resp_rise: assert property (do_write |-> s_write_taken)
    else $error("write response not raised");
  a_write_resp_hold: assert property ((BVALID && !BREADY) |=> BVALID)
    else $error("write response dropped early");
  a_fmt_reserved: assert property ((do_write && wstrb_reg[0] && wr_hit == REG_FMT) |=>
    fmt_reg == (($past(wdata_reg[7:0]) & 8'h1F)))
    else $error("format register write wrong");
  a_slg_reserved: assert property (slg_reg[3:2] == 2'h2 && eq_reg[7] == 1'b0)
    else $error("reserved default lost");
  a_off_quiet: assert property (pd |=> !RX_DATA_OUT && !RX_PLUS_RAIL_OUT && !RX_CLK_OUT)
    else $error("outputs active while powered down");
  a_dual_polarity: assert property ((mode == DEC_DUAL && bit_tick && !pd && !ais_active) |=>
    RX_PLUS_RAIL_OUT == ($past(pos_s) ^ $past(inv)))
    else $error("dual rail data wrong");
  a_dual_edge_hold: assert property ((mode == DEC_DUAL && !bit_tick && !pd && !ais_active) |=>
    $stable(RX_PLUS_RAIL_OUT))
    else $error("dual rail changed off edge");
  a_slicer_follow: assert property ((mode == DEC_SLICER && !pd && !ais_active) |=>
    RX_MINUS_RAIL_OUT == ($past(sneg_s) ^ $past(inv)))
    else $error("slicer rail wrong");
  a_hdb3_strip: assert property ((mode == DEC_HDB3 && bit_tick && viol) |=> hist_reg == 4'h0)
    else $error("violation not removed");
  a_ami_data: assert property ((mode == DEC_AMI && bit_tick && !pd && !ais_active) |=>
    RX_DATA_OUT == ($past(hist_reg[3]) ^ $past(inv)))
    else $error("single rail data wrong");
  a_prbs_tx: assert property ((patt == PAT_PRBS && pat_tick) |=>
    TX_DATA_OUT == ($past(prbs_reg[14]) ^ $past(pinv)))
    else $error("prbs transmit wrong");
  a_ones_fill: assert property ((patt == PAT_NORMAL && ones_fill && los_s && pat_tick) |=>
    TX_DATA_OUT)
    else $error("ones fill missing");
  a_ais_clock: assert property ((ais_active && !pd) [*2] |=>
    RX_CLK_OUT != $past(RX_CLK_OUT))
    else $error("alarm clock not toggling");

endmodule
`default_nettype wire

/* e1_rx_config_diag_regs_tb.sv */
// Self-checking bench for the E1 receive configuration and diagnostic bank
`timescale 1ns/100ps
`default_nettype none
module e1_rx_config_diag_regs_tb import e1_rx_pkg::*; ;
  logic MCLK = 1'b0;
  logic ARST_N = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic RX_POS_IN = 1'b0, RX_NEG_IN = 1'b0, RX_SLICE_POS_IN = 1'b0, RX_SLICE_NEG_IN = 1'b0;
  logic RX_CLK_IN = 1'b0, LOS_IN = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_CLOCK_IN, TX_DATA_IN, TX_DATA_OUT;
  logic RX_DATA_OUT, RX_PLUS_RAIL_OUT, RX_MINUS_RAIL_OUT, RX_CLK_OUT, PRBS_ERR_OUT;
  logic [1:0] BRESP, RRESP, resp;
  logic [31:0] RDATA, rd;
  logic [15:0] rises, r0, p0;
  logic [15:0] n_perr = 16'h0000;
  logic [39:0] bits;
  logic [9:0] seq = 10'b1011001011;
  analog_ctrl_t ANALOG_CTRL;
  logic [7:0] addrs [4] = '{8'h28, 8'h2C, 8'h30, 8'h34};
  logic [7:0] rstv [4] = '{8'h00, 8'h15, 8'h18, 8'h00};
  logic [7:0] maskv [4] = '{8'h1F, 8'h5F, 8'h33, 8'h7F};
  int n_errors = 0, samples_checked = 0, cycles = 0;
  logic par;

  e1_rx_config_diag_regs u_dut (
    .MCLK(MCLK), .ARST_N(ARST_N),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RX_POS_IN(RX_POS_IN), .RX_NEG_IN(RX_NEG_IN), .RX_SLICE_POS_IN(RX_SLICE_POS_IN),
    .RX_SLICE_NEG_IN(RX_SLICE_NEG_IN), .RX_CLK_IN(RX_CLK_IN), .LOS_IN(LOS_IN),
    .TX_CLOCK_IN(TX_CLOCK_IN), .TX_DATA_IN(TX_DATA_IN), .TX_DATA_OUT(TX_DATA_OUT),
    .RX_DATA_OUT(RX_DATA_OUT), .RX_PLUS_RAIL_OUT(RX_PLUS_RAIL_OUT),
    .RX_MINUS_RAIL_OUT(RX_MINUS_RAIL_OUT), .RX_CLK_OUT(RX_CLK_OUT),
    .PRBS_ERR_OUT(PRBS_ERR_OUT), .ANALOG_CTRL(ANALOG_CTRL)
  );
  e1_framer_model u_framer (
    .mclk(MCLK), .arst_n(ARST_N), .rx_clk(RX_CLK_OUT),
    .tx_clk(TX_CLOCK_IN), .tx_data(TX_DATA_IN), .rx_rises(rises)
  );

  // Master clock at 10 MHz
  always #50 MCLK = ~MCLK;
  // Count checker error pulses; each stands for exactly one cycle
  always @(posedge MCLK) if (PRBS_ERR_OUT === 1'b1) n_perr <= n_perr + 16'h0001;
  // Cycle ceiling well above the run length cuts a hang short
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  // Write one byte; handshakes are judged on values settled before the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, b;
    int t;
    t = 0;
    b = 1'b0;
    @(posedge MCLK);
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= {24'hA5A5A5, d};
    WSTRB <= 4'hF;
    BREADY <= 1'b1;
    while (!b && t < 100) begin
      @(negedge MCLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID && BREADY;
      resp = BRESP;
      @(posedge MCLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      t++;
    end
    BREADY <= 1'b0;
    if (!b) n_errors++;
  endtask

  task automatic rdr(input logic [7:0] a);
    logic ar, r;
    int t;
    t = 0;
    r = 1'b0;
    @(posedge MCLK);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    while (!r && t < 100) begin
      @(negedge MCLK);
      ar = ARVALID && ARREADY;
      r = RVALID && RREADY;
      rd = RDATA;
      resp = RRESP;
      @(posedge MCLK);
      if (ar) ARVALID <= 1'b0;
      t++;
    end
    RREADY <= 1'b0;
    if (!r) n_errors++;
  endtask

  // One line bit: rails set, recovered clock high then low, slow enough to sample
  task automatic rx_bit(input logic p, input logic n);
    RX_POS_IN <= p;
    RX_NEG_IN <= n;
    cyc(4);
    RX_CLK_IN <= 1'b1;
    cyc(5);
    RX_CLK_IN <= 1'b0;
    cyc(5);
  endtask

  initial begin
    cyc(6);
    ARST_N <= 1'b1;
    // Reset values, then writable masks with reserved bits held at default
    for (int i = 0; i < 4; i++) begin
      rdr(addrs[i]);
      chk("reset value", rd, {24'h0, rstv[i]});
      wr(addrs[i], 8'hFF);
      rdr(addrs[i]);
      chk("ones readback", rd, {24'h0, maskv[i] | (rstv[i] & ~maskv[i])});
      wr(addrs[i], rstv[i]);
    end
    wr(8'h3C, 8'h01);
    chk("unmapped write", resp, 2'h3);
    rdr(8'h3C);
    chk("unmapped read", resp, 2'h3);
    // Analog settings: equalizer, threshold codes, slicer and gain codes, criterion
    chk("eq off", {ANALOG_CTRL.equalizer_switch, ANALOG_CTRL.signal_absent_threshold}, 6'h15);
    wr(8'h2C, 8'h4A);
    cyc(3);
    chk("equalizer_switch", ANALOG_CTRL.equalizer_switch, 1'b1);
    chk("threshold", ANALOG_CTRL.signal_absent_threshold, 5'h0A);
    wr(8'h2C, 8'h4B);
    cyc(3);
    chk("reserved code", ANALOG_CTRL.signal_absent_threshold, 5'h0A);
    for (int k = 0; k < 4; k++) begin
      wr(8'h30, {2'h0, k[1:0], 2'h2, k[1:0]});
      cyc(3);
      chk("slicer", ANALOG_CTRL.detector_threshold_sel, k[1:0]);
      chk("gain", ANALOG_CTRL.monitor_boost, k[1:0]);
    end
    wr(8'h34, 8'h04);
    cyc(3);
    chk("criterion", ANALOG_CTRL.alarm_criterion_sel, 1'b1);
    // Dual rail, polarity, clock edge, slicer and power down
    wr(8'h28, 8'h02);
    rx_bit(1'b1, 1'b0);
    chk("dual plus", {RX_PLUS_RAIL_OUT, RX_MINUS_RAIL_OUT, RX_DATA_OUT}, 3'h4);
    rx_bit(1'b0, 1'b1);
    chk("dual minus", {RX_PLUS_RAIL_OUT, RX_MINUS_RAIL_OUT}, 2'h1);
    wr(8'h28, 8'h0A);
    rx_bit(1'b1, 1'b0);
    chk("inverted", {RX_PLUS_RAIL_OUT, RX_MINUS_RAIL_OUT}, 2'h1);
    wr(8'h28, 8'h06);
    rx_bit(1'b0, 1'b0);
    RX_POS_IN <= 1'b1;
    cyc(4);
    RX_CLK_IN <= 1'b1;
    cyc(6);
    chk("rise ignored", RX_PLUS_RAIL_OUT, 1'b0);
    RX_CLK_IN <= 1'b0;
    cyc(6);
    chk("fall updates", RX_PLUS_RAIL_OUT, 1'b1);
    wr(8'h28, 8'h07);
    RX_SLICE_POS_IN <= 1'b1;
    cyc(5);
    chk("slicer rails", {RX_PLUS_RAIL_OUT, RX_MINUS_RAIL_OUT}, 2'h2);
    RX_SLICE_POS_IN <= 1'b0;
    wr(8'h28, 8'h12);
    rx_bit(1'b1, 1'b0);
    chk("power down", {RX_PLUS_RAIL_OUT, ANALOG_CTRL.rx_power_down}, 2'h1);
    // HDB3 and AMI decode, single rail output four bits late
    for (int m = 0; m < 2; m++) begin
      wr(8'h28, m[7:0]);
      // A negative mark first, so the sequence starts on a legal positive mark
      rx_bit(1'b0, 1'b1);
      par = 1'b0;
      for (int i = 0; i < 10; i++) begin
        rx_bit(seq[i] && !par, seq[i] && par);
        par = par ^ seq[i];
        if (i >= 4) chk("decoded", {RX_DATA_OUT, RX_PLUS_RAIL_OUT}, {seq[i-4], 1'b0});
      end
      // Mark, two zeros, same-polarity mark: HDB3 erases the first mark, AMI keeps it
      for (int j = 0; j < 5; j++) rx_bit(j == 0 || j == 3, 1'b0);
      chk("violation", RX_DATA_OUT, m[0]);
    end
    // Transmit: normal, zero insertion, all ones, ones fill during absence
    wr(8'h34, 8'h00);
    cyc(20);
    chk("normal tx", TX_DATA_OUT, 1'b1);
    wr(8'h34, 8'h10);
    cyc(6);
    chk("zeros tx", TX_DATA_OUT, 1'b0);
    wr(8'h34, 8'h31);
    cyc(6);
    chk("ones tx", TX_DATA_OUT, 1'b1);
    wr(8'h34, 8'h11);
    LOS_IN <= 1'b1;
    cyc(8);
    chk("ones fill", TX_DATA_OUT, 1'b1);
    // Alarm fill on the recovered clock during absence, then disabled
    wr(8'h28, 8'h02);
    for (int e = 1; e >= 0; e--) begin
      wr(8'h34, {6'h0, e[0], 1'b0});
      cyc(6);
      r0 = rises;
      cyc(20);
      chk("alarm clock", rises - r0, e ? 16'd10 : 16'd0);
    end
    LOS_IN <= 1'b0;
    // Pseudo-random pattern on the master clock, plain then inverted
    for (int v = 0; v < 2; v++) begin
      wr(8'h34, v ? 8'h58 : 8'h50);
      cyc(4);
      for (int n = 0; n < 40; n++) begin
        @(negedge MCLK);
        bits[n] = TX_DATA_OUT;
      end
      for (int n = 15; n < 40; n++) begin
        chk("prbs", bits[n] ^ bits[n-14] ^ bits[n-15], v[0]);
      end
      @(posedge MCLK);
    end
    // A lone mark in a zero stream trips the self-synchronising check three times
    wr(8'h34, 8'h40);
    wr(8'h28, 8'h01);
    for (int i = 0; i < 41; i++) begin
      if (i == 20) p0 = n_perr;
      rx_bit(i == 20, 1'b0);
    end
    chk("prbs errors", n_perr - p0, 16'h0003);
    end_of_test();
  end
endmodule
`default_nettype wire

/* e1_rx_defines.svh */
// Register indices, field positions and reset values of the E1 receive config bank
`ifndef E1_RX_DEFINES_SVH
`define E1_RX_DEFINES_SVH
// Register indices; the byte address is four times the index
`define IDX_RX_FMT 6'h0A
`define IDX_RX_EQ 6'h0B
`define IDX_RX_SLG 6'h0C
`define IDX_DIAG 6'h0D
`define IDX_STATUS 6'h20
// Receive output format control fields
`define RX_OFF_BIT 4
`define RX_POL_BIT 3
`define RX_EDGE_BIT 2
// Equalizer and threshold fields
`define EQ_SWITCH_BIT 6
`define LOS_LSB 0
`define LOS_MAX 5'h0A
// Threshold code handed on while the equalizer is off
`define RST_LOS 5'h15
// Slicer and gain fields
`define SLICE_LSB 4
`define GAIN_LSB 0
// Diagnostic pattern fields
`define TSEQ_LSB 5
`define PCLK_BIT 4
`define PINV_BIT 3
`define CRIT_BIT 2
`define AIS_FILL_BIT 1
`define ONES_FILL_BIT 0
// Reset values, reserved bits included
`define RST_RX_FMT 8'h00
`define RST_RX_EQ 8'h15
`define RST_RX_SLG 8'h18
`define RST_DIAG 8'h00
// Writable bit masks; other bits keep their reset value
`define WM_RX_FMT 8'h1F
`define WM_RX_EQ 8'h5F
`define WM_RX_SLG 8'h33
`define WM_DIAG 8'h7F
// Pseudo-random generator seed
`define PRBS_SEED 15'h7FFF
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

/* e1_rx_pkg.sv */
// Types shared by the E1 receive configuration bank
package e1_rx_pkg;
  typedef enum logic [1:0] {
    DEC_HDB3 = 2'h0,
    DEC_AMI = 2'h1,
    DEC_DUAL = 2'h2,
    DEC_SLICER = 2'h3
  } decode_mode_t;
  typedef enum logic [1:0] {
    PAT_NORMAL = 2'h0,
    PAT_ONES = 2'h1,
    PAT_PRBS = 2'h2,
    PAT_RSVD = 2'h3
  } pattern_t;
  typedef enum logic [2:0] {
    REG_FMT = 3'h0,
    REG_EQ = 3'h1,
    REG_SLG = 3'h2,
    REG_DIAG = 3'h3,
    REG_STAT = 3'h4,
    REG_NONE = 3'h7
  } reg_sel_t;
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_RESP = 2'h1
  } wr_state_t;
  typedef struct packed {
    logic rx_power_down;
    logic equalizer_switch;
    logic [4:0] signal_absent_threshold;
    logic [1:0] detector_threshold_sel;
    logic [1:0] monitor_boost;
    logic alarm_criterion_sel;
  } analog_ctrl_t;
endpackage
